// File: sbcc_panel_model.sv
// Behavioural glass panel that shows the segment states it is driven with.
// Assumes seg_drive and frame_pulse come from the controller on the same clock.
`timescale 1ns/1ps
module sbcc_panel_model (
    input wire logic clk, // System clock.
    input wire logic [63:0] seg_drive, // Segment on states from the controller.
    input wire logic frame_pulse, // Frame start pulse.
    output logic [63:0] lit, // Segments visibly on.
    output int frames // Frame starts seen so far.
);
    int frame_cnt = 0;

    assign frames = frame_cnt;
    // Real glass settles over many frames; only the commanded state matters here.
    always @(posedge clk) begin
        lit <= seg_drive;
        if (frame_pulse === 1'b1) begin
            frame_cnt <= frame_cnt + 1;
        end
    end
endmodule

// File: sbcc_pkg.sv
// Shared constants and types for the segment blink and command controller.
// Assumes a single 50 MHz clock and an 8-bit register port with a 6-bit address.
package sbcc_pkg;

    localparam int CLK_HZ = 50_000_000;
    localparam int BASE_HZ = 32_768;
    // Waveform base clock is approximated by an integer divider, so it runs slightly fast.
    localparam int BASE_DIV = CLK_HZ / BASE_HZ;
    localparam int FRAME_BASE_TICKS = 64;
    localparam int BLINK_EXP_BASE = 5;

    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam int SEG_BYTES = 8;
    localparam int SEG_BITS = SEG_BYTES * DATA_W;
    localparam int BLINK_CNT_W = 12;

    localparam logic [5:0] ADDR_BLINK_CTRL = 6'h00;
    localparam logic [5:0] ADDR_CMD = 6'h01;
    localparam logic [5:0] ADDR_DISP_CTRL = 6'h02;
    localparam logic [5:0] ADDR_IRQ_STATUS = 6'h03;
    localparam logic [5:0] ADDR_IRQ_CLEAR = 6'h04;
    localparam logic [5:0] ADDR_IRQ_ENABLE = 6'h05;
    localparam logic [2:0] ADDR_SEG_PAGE = 3'h1;

    localparam int BC_BLINK_BIT = 7;
    localparam int BC_SCOPE_BIT = 3;
    localparam int BC_RATE_LSB = 0;
    localparam int CMD_IRQF_BIT = 7;
    localparam int CMD_BANK_BIT = 3;
    localparam int CMD_CLR_BIT = 1;
    localparam int CMD_BLANK_BIT = 0;
    localparam int DC_ENABLE_BIT = 0;
    localparam int EV_FRAME_BIT = 0;
    localparam int EV_CLEAR_BIT = 1;
    localparam int EV_W = 2;

    localparam logic [7:0] BLINK_CTRL_RST = 8'h00;
    localparam logic [7:0] CMD_RST = 8'h00;
    localparam logic [7:0] DISP_CTRL_RST = 8'h00;
    localparam logic [1:0] IRQ_ENABLE_RST = 2'h0;

    typedef struct packed {
        logic blink;
        logic scope;
        logic [2:0] rate;
    } sbcc_blink_cfg_t;

    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sbcc_bus_req_t;

endpackage

// File: sbcc_sticky.sv
// Bank of sticky flags; a set in the same cycle as a clear wins.
// Assumes set and clr come from logic on the same clock.
`timescale 1ns/1ps
module sbcc_sticky #(
    parameter int W = 1
) (
    input wire logic clk, // System clock.
    input wire logic srst, // Synchronous reset, active high.
    input wire logic [W-1:0] set, // Per-bit set pulses.
    input wire logic [W-1:0] clr, // Per-bit clear pulses.
    output logic [W-1:0] q // Flag state.
);
    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= (q & ~clr) | set;
        end
    end
endmodule

// File: sbcc_tick_div.sv
// Enable-pulse divider: one-cycle tick every DIV enabled cycles.
// Assumes en comes from logic on the same clock.
`timescale 1ns/1ps
module sbcc_tick_div #(
    parameter int DIV = 2
) (
    input wire logic clk, // System clock.
    input wire logic srst, // Synchronous reset, active high.
    input wire logic en, // Count enable.
    output logic tick // One-cycle pulse every DIV enables.
);
    localparam int CW = $clog2(DIV);
    logic [CW-1:0] cnt_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_reg <= '0;
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (en) begin
                if (cnt_reg == CW'(DIV - 1)) begin
                    cnt_reg <= '0;
                    tick <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + 1'b1;
                end
            end
        end
    end
endmodule

// File: sbcc_top.sv
// Blink, command and status control for a multiplexed segment display.
// Assumes a register master on the same clock and a waveform generator fed by seg_drive.
`timescale 1ns/1ps
module sbcc_top (
    input wire logic clk, // 50 MHz system clock.
    input wire logic srst, // Synchronous reset, active high.
    input wire logic [5:0] addr, // Register address.
    input wire logic [7:0] wdata, // Write data.
    input wire logic wr, // Write strobe, one cycle.
    input wire logic rd, // Read strobe, one cycle.
    output logic [7:0] rdata, // Read data, valid the cycle after rd.
    output logic [63:0] seg_drive, // Per-segment on state for the waveform generator.
    output logic frame_pulse, // One-cycle pulse at each frame start.
    output logic irq // Level interrupt.
);
    sbcc_pkg::sbcc_bus_req_t req;
    sbcc_pkg::sbcc_blink_cfg_t blink_cfg_reg;
    logic blank_reg;
    logic bank_reg;
    logic enable_reg;
    logic [1:0] irq_en_reg;
    logic [7:0] on_mem [sbcc_pkg::SEG_BYTES];
    logic [7:0] blen_mem [sbcc_pkg::SEG_BYTES];
    logic [63:0] on_vec;
    logic [63:0] blen_vec;
    logic clr_busy_reg;
    logic clr_bank_reg;
    logic [2:0] clr_idx_reg;
    logic clr_done;
    logic armed_reg;
    logic frame_flag;
    logic [1:0] ev_status;
    logic base_tick;
    logic frame_tick;
    logic blink_active_reg;
    logic phase_off_reg;
    logic [11:0] blink_cnt_reg;
    logic [3:0] phase_idx;
    logic [5:0] frame_cnt_reg;
    logic bc_hit;
    logic cmd_hit;
    logic dc_hit;
    logic ie_hit;
    logic icl_hit;
    logic seg_hit;
    logic flag_clr;
    logic clr_start;

    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
    assign bc_hit = req.addr == sbcc_pkg::ADDR_BLINK_CTRL;
    assign cmd_hit = req.addr == sbcc_pkg::ADDR_CMD;
    assign dc_hit = req.addr == sbcc_pkg::ADDR_DISP_CTRL;
    assign ie_hit = req.addr == sbcc_pkg::ADDR_IRQ_ENABLE;
    assign icl_hit = req.addr == sbcc_pkg::ADDR_IRQ_CLEAR;
    assign seg_hit = req.addr[5:3] == sbcc_pkg::ADDR_SEG_PAGE;
    assign clr_start = req.wr && cmd_hit && req.wdata[sbcc_pkg::CMD_CLR_BIT] && !clr_busy_reg;
    assign flag_clr = req.wr && cmd_hit && req.wdata[sbcc_pkg::CMD_IRQF_BIT] && armed_reg;
    assign clr_done = clr_busy_reg && (clr_idx_reg == 3'h7);
    assign phase_idx = 4'(sbcc_pkg::BLINK_EXP_BASE - 1) + {1'b0, blink_cfg_reg.rate};

    always_comb begin
        for (int i = 0; i < sbcc_pkg::SEG_BYTES; i++) begin
            on_vec[i*8 +: 8] = on_mem[i];
            blen_vec[i*8 +: 8] = blen_mem[i];
        end
    end

    // Frame timing runs whenever the display is enabled; blank does not gate it.
    sbcc_tick_div #(.DIV(sbcc_pkg::BASE_DIV)) base_div (
        .clk(clk),
        .srst(srst),
        .en(1'b1),
        .tick(base_tick)
    );

    sbcc_tick_div #(.DIV(sbcc_pkg::FRAME_BASE_TICKS)) frame_div (
        .clk(clk),
        .srst(srst),
        .en(base_tick && enable_reg),
        .tick(frame_tick)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            frame_cnt_reg <= '0;
        end else if (base_tick && enable_reg) begin
            frame_cnt_reg <= frame_cnt_reg + 1'b1;
        end
    end

    // Control registers.
    always_ff @(posedge clk) begin
        if (srst) begin
            blink_cfg_reg <= '{blink: sbcc_pkg::BLINK_CTRL_RST[sbcc_pkg::BC_BLINK_BIT],
                               scope: sbcc_pkg::BLINK_CTRL_RST[sbcc_pkg::BC_SCOPE_BIT],
                               rate: sbcc_pkg::BLINK_CTRL_RST[2:0]};
            blank_reg <= sbcc_pkg::CMD_RST[sbcc_pkg::CMD_BLANK_BIT];
            bank_reg <= sbcc_pkg::CMD_RST[sbcc_pkg::CMD_BANK_BIT];
            enable_reg <= sbcc_pkg::DISP_CTRL_RST[sbcc_pkg::DC_ENABLE_BIT];
            irq_en_reg <= sbcc_pkg::IRQ_ENABLE_RST;
        end else if (req.wr) begin
            if (bc_hit) begin
                blink_cfg_reg.blink <= req.wdata[sbcc_pkg::BC_BLINK_BIT];
                blink_cfg_reg.scope <= req.wdata[sbcc_pkg::BC_SCOPE_BIT];
                blink_cfg_reg.rate <= req.wdata[sbcc_pkg::BC_RATE_LSB +: 3];
            end
            if (cmd_hit) begin
                blank_reg <= req.wdata[sbcc_pkg::CMD_BLANK_BIT];
                bank_reg <= req.wdata[sbcc_pkg::CMD_BANK_BIT];
            end
            if (dc_hit) begin
                enable_reg <= req.wdata[sbcc_pkg::DC_ENABLE_BIT];
            end
            if (ie_hit) begin
                irq_en_reg <= req.wdata[sbcc_pkg::EV_W-1:0];
            end
        end
    end

    // Segment memory: bus writes go to the selected bank; a running clear overrides its byte.
    always_ff @(posedge clk) begin
        if (srst) begin
            for (int i = 0; i < sbcc_pkg::SEG_BYTES; i++) begin
                on_mem[i] <= 8'h00;
                blen_mem[i] <= 8'h00;
            end
        end else begin
            if (req.wr && seg_hit) begin
                if (bank_reg) begin
                    blen_mem[req.addr[2:0]] <= req.wdata;
                end else begin
                    on_mem[req.addr[2:0]] <= req.wdata;
                end
            end
            if (clr_busy_reg) begin
                if (clr_bank_reg) begin
                    blen_mem[clr_idx_reg] <= 8'h00;
                end else begin
                    on_mem[clr_idx_reg] <= 8'h00;
                end
            end
        end
    end

    // Clear walks one byte per cycle, so it finishes eight cycles after the command.
    always_ff @(posedge clk) begin
        if (srst) begin
            clr_busy_reg <= 1'b0;
            clr_bank_reg <= 1'b0;
            clr_idx_reg <= 3'h0;
        end else if (clr_start) begin
            clr_busy_reg <= 1'b1;
            clr_bank_reg <= bank_reg;
            clr_idx_reg <= 3'h0;
        end else if (clr_busy_reg) begin
            clr_idx_reg <= clr_idx_reg + 1'b1;
            if (clr_done) begin
                clr_busy_reg <= 1'b0;
            end
        end
    end

    // The flag clears only on a write of 1 that follows a read showing it set.
    always_ff @(posedge clk) begin
        if (srst) begin
            armed_reg <= 1'b0;
        end else if (req.rd && cmd_hit && frame_flag) begin
            armed_reg <= 1'b1;
        end else if ((req.wr && cmd_hit) || !frame_flag) begin
            armed_reg <= 1'b0;
        end
    end

    sbcc_sticky #(.W(1)) flag_unit (
        .clk(clk),
        .srst(srst),
        .set(frame_tick),
        .clr(flag_clr),
        .q(frame_flag)
    );

    sbcc_sticky #(.W(sbcc_pkg::EV_W)) status_unit (
        .clk(clk),
        .srst(srst),
        .set({clr_done, frame_tick}),
        .clr((req.wr && icl_hit) ? req.wdata[sbcc_pkg::EV_W-1:0] : 2'h0),
        .q(ev_status)
    );

    // Blink state: command and phase only move at frame boundaries.
    always_ff @(posedge clk) begin
        if (srst) begin
            blink_active_reg <= 1'b0;
            phase_off_reg <= 1'b0;
        end else if (frame_tick) begin
            blink_active_reg <= blink_cfg_reg.blink;
            phase_off_reg <= blink_cfg_reg.blink && blink_cnt_reg[phase_idx];
        end
    end

    // Counter bit 4+rate toggles every 2^(4+rate) base ticks, a period of 2^(5+rate).
    always_ff @(posedge clk) begin
        if (srst) begin
            blink_cnt_reg <= '0;
        end else if (!blink_active_reg) begin
            blink_cnt_reg <= '0;
        end else if (base_tick) begin
            blink_cnt_reg <= blink_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            seg_drive <= '0;
        end else if (blank_reg || !enable_reg) begin
            seg_drive <= '0;
        end else if (blink_active_reg && phase_off_reg) begin
            if (blink_cfg_reg.scope) begin
                seg_drive <= '0;
            end else begin
                seg_drive <= on_vec & ~blen_vec;
            end
        end else begin
            seg_drive <= on_vec;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            frame_pulse <= 1'b0;
            irq <= 1'b0;
        end else begin
            frame_pulse <= frame_tick;
            irq <= |(ev_status & irq_en_reg);
        end
    end

    // Read port; unmapped addresses and write-only registers read as zero.
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= 8'h00;
        end else if (req.rd) begin
            rdata <= 8'h00;
            if (bc_hit) begin
                rdata[sbcc_pkg::BC_BLINK_BIT] <= blink_cfg_reg.blink;
                rdata[sbcc_pkg::BC_SCOPE_BIT] <= blink_cfg_reg.scope;
                rdata[sbcc_pkg::BC_RATE_LSB +: 3] <= blink_cfg_reg.rate;
            end else if (cmd_hit) begin
                rdata[sbcc_pkg::CMD_IRQF_BIT] <= frame_flag;
                rdata[sbcc_pkg::CMD_BANK_BIT] <= bank_reg;
                rdata[sbcc_pkg::CMD_BLANK_BIT] <= blank_reg;
            end else if (dc_hit) begin
                rdata[sbcc_pkg::DC_ENABLE_BIT] <= enable_reg;
            end else if (req.addr == sbcc_pkg::ADDR_IRQ_STATUS) begin
                rdata[sbcc_pkg::EV_W-1:0] <= ev_status;
            end else if (ie_hit) begin
                rdata[sbcc_pkg::EV_W-1:0] <= irq_en_reg;
            end else if (seg_hit) begin
                rdata <= bank_reg ? blen_mem[req.addr[2:0]] : on_mem[req.addr[2:0]];
            end
        end else begin
            rdata <= 8'h00;
        end
    end

    blink_frame_a: assert property (@(posedge clk) disable iff (srst)
        !frame_tick |=> $stable(blink_active_reg))
        else $error("blink state changed away from a frame boundary");

    scope_all_a: assert property (@(posedge clk) disable iff (srst)
        (blink_active_reg && phase_off_reg && blink_cfg_reg.scope) |=> (seg_drive == '0))
        else $error("segment lit during whole-panel blink off phase");

    scope_seg_a: assert property (@(posedge clk) disable iff (srst)
        (blink_active_reg && phase_off_reg && !blink_cfg_reg.scope && blen_vec[0])
        |=> !seg_drive[0])
        else $error("blink-enabled segment lit during off phase");

    blank_off_a: assert property (@(posedge clk) disable iff (srst)
        blank_reg |=> (seg_drive == '0))
        else $error("segment driven while blanked");

    timing_runs_a: assert property (@(posedge clk) disable iff (srst)
        (blank_reg && enable_reg && base_tick) |=> (frame_cnt_reg != $past(frame_cnt_reg)))
        else $error("frame timing stalled while blanked");

    on_show_a: assert property (@(posedge clk) disable iff (srst)
        (!blank_reg && enable_reg && !blink_active_reg && on_vec[0]) |=> seg_drive[0])
        else $error("on segment not shown");

    clr_read_a: assert property (@(posedge clk) disable iff (srst)
        (req.rd && cmd_hit) |=> !rdata[sbcc_pkg::CMD_CLR_BIT])
        else $error("clear command bit read as one");

    clr_finish_a: assert property (@(posedge clk) disable iff (srst)
        clr_start |=> clr_busy_reg ##[7:8] !clr_busy_reg)
        else $error("bank clear did not finish in eight cycles");

    flag_clear_a: assert property (@(posedge clk) disable iff (srst)
        $fell(frame_flag) |-> $past(armed_reg) && $past(req.wr))
        else $error("frame flag cleared without read then write");

    flag_set_a: assert property (@(posedge clk) disable iff (srst)
        frame_tick |=> frame_flag)
        else $error("frame flag not set at frame start");

    irq_follow_a: assert property (@(posedge clk) disable iff (srst)
        ((ev_status & irq_en_reg) != 2'h0) |=> irq)
        else $error("interrupt low with an enabled event pending");

    steady_show_a: assert property (@(posedge clk) disable iff (srst)
        (!blink_active_reg && !blank_reg && enable_reg) |=> (seg_drive == $past(on_vec)))
        else $error("image changed while blinking is stopped");

    phase_frame_a: assert property (@(posedge clk) disable iff (srst)
        !frame_tick |=> $stable(phase_off_reg))
        else $error("blink phase changed away from a frame boundary");

    clr_hold_a: assert property (@(posedge clk) disable iff (srst)
        (clr_busy_reg && !clr_done)
        |=> (clr_busy_reg && (clr_idx_reg == $past(clr_idx_reg) + 3'h1)))
        else $error("bank clear stopped before its last byte");

    rd_idle_a: assert property (@(posedge clk) disable iff (srst)
        !req.rd |=> (rdata == 8'h00))
        else $error("read data stood longer than one cycle");
endmodule

// File: segment_blink_command_ctrl_test.sv
// Self-checking bench for the segment blink and command controller.
// Assumes the package constants and a single 50 MHz clock.
`timescale 1ns/1ps
`define CHECK(nm, exp, got) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); \
        end \
    end
module segment_blink_command_ctrl_test;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [5:0] addr = 6'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [63:0] seg_drive;
    logic frame_pulse;
    logic irq;
    logic [63:0] lit;
    int frames;
    int mismatches = 0;
    int comparisons = 0;
    logic [63:0] on_pat;
    logic [63:0] blk_pat;

    always #10 clk = ~clk;

    sbcc_top i_dut (
        .clk(clk),
        .srst(srst),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd(rd),
        .rdata(rdata),
        .seg_drive(seg_drive),
        .frame_pulse(frame_pulse),
        .irq(irq)
    );

    sbcc_panel_model i_panel (
        .clk(clk),
        .seg_drive(seg_drive),
        .frame_pulse(frame_pulse),
        .lit(lit),
        .frames(frames)
    );

    task automatic print_verdict();
        if (mismatches == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic bus_write(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic bus_check(input logic [5:0] a, input logic [7:0] exp, input string nm);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHECK(nm, exp, rdata)
    endtask

    task automatic write_bank(input logic [63:0] v);
        for (int i = 0; i < 8; i++) begin
            bus_write(6'h08 + 6'(i), v[8*i +: 8]);
        end
    endtask

    task automatic check_bank(input logic [63:0] exp, input string nm);
        for (int i = 0; i < 8; i++) begin
            bus_check(6'h08 + 6'(i), exp[8*i +: 8], nm);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One frame is about 97600 cycles, so the run is reckoned around a single frame.
    initial begin
        repeat (105000) @(posedge clk);
        mismatches++;
        print_verdict();
    end

    initial begin
        for (int i = 0; i < 8; i++) begin
            on_pat[8*i +: 8] = 8'h11 * 8'(i + 1);
            blk_pat[8*i +: 8] = 8'hF0 ^ 8'(i);
        end
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        bus_check(6'h00, 8'h00, "blink_control reset");
        bus_check(6'h01, 8'h00, "command reset");
        bus_check(6'h02, 8'h00, "display control reset");
        bus_check(6'h05, 8'h00, "irq enable reset");
        bus_check(6'h06, 8'h00, "unmapped read");
        bus_write(6'h00, 8'h0D);
        bus_check(6'h00, 8'h0D, "blink_control readback");
        settle(1);
        `CHECK("rdata idle", 8'h00, rdata)
        bus_write(6'h02, 8'h01);
        write_bank(on_pat);
        settle(4);
        `CHECK("shown image", on_pat, lit)
        bus_write(6'h01, 8'h08);
        write_bank(blk_pat);
        settle(4);
        `CHECK("image with bank 1", on_pat, lit)
        check_bank(blk_pat, "blink bank");
        bus_write(6'h01, 8'h00);
        check_bank(on_pat, "on/off bank");
        bus_write(6'h01, 8'h01);
        settle(4);
        `CHECK("blanked image", 64'h0, lit)
        bus_check(6'h01, 8'h01, "blank readback");
        bus_write(6'h01, 8'h00);
        settle(4);
        `CHECK("unblanked image", on_pat, lit)
        bus_write(6'h01, 8'h08);
        bus_write(6'h01, 8'h0A);
        bus_check(6'h01, 8'h08, "clear bit reads zero");
        settle(10);
        check_bank(64'h0, "blink bank after clear");
        bus_write(6'h01, 8'h00);
        check_bank(on_pat, "on/off bank after clear");
        bus_check(6'h03, 8'h02, "clear done status");
        bus_write(6'h05, 8'h02);
        settle(3);
        `CHECK("irq enabled", 1'b1, irq)
        bus_write(6'h05, 8'h00);
        settle(3);
        `CHECK("irq masked", 1'b0, irq)
        bus_write(6'h04, 8'h02);
        bus_check(6'h03, 8'h00, "status cleared");
        // Scope goes to 0 before blinking starts, so it never changes while blinking.
        bus_write(6'h05, 8'h01);
        bus_check(6'h05, 8'h01, "irq enable readback");
        bus_write(6'h00, 8'h00);
        bus_write(6'h00, 8'h80);
        bus_write(6'h01, 8'h01);
        while (frames == 0) begin
            @(posedge clk);
        end
        settle(3);
        `CHECK("frame while blanked", 1, frames)
        `CHECK("frame irq", 1'b1, irq)
        `CHECK("blank held over frame", 64'h0, lit)
        bus_write(6'h01, 8'h80);
        bus_check(6'h01, 8'h80, "flag kept without read");
        bus_write(6'h01, 8'h80);
        bus_check(6'h01, 8'h00, "flag cleared");
        settle(4);
        `CHECK("blink with empty enables", on_pat, lit)
        bus_write(6'h04, 8'h01);
        settle(3);
        `CHECK("irq after status clear", 1'b0, irq)
        print_verdict();
    end
endmodule
